// File: drob_pkg.sv
/*
 * Package for the extended diagnostic record builder: register map,
 * record layout constants, mode encoding and event carrier struct.
 * Assumes a 32-bit APB slave at word-aligned byte addresses.
 */
package drob_pkg;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [11:0] DROB_OFF_CTRL = 12'h000;
    localparam logic [11:0] DROB_OFF_BASE = 12'h004;
    localparam logic [11:0] DROB_OFF_REC0 = 12'h010;
    localparam logic [11:0] DROB_OFF_REC1 = 12'h014;
    localparam logic [11:0] DROB_OFF_REC2 = 12'h018;
    localparam logic [11:0] DROB_OFF_REC3 = 12'h01C;
    localparam logic [11:0] DROB_OFF_STAT = 12'h020;
    localparam logic [11:0] DROB_OFF_MASK = 12'h024;

    // ========================================================
    // Control register fields
    localparam int DROB_CTRL_MODE_BIT = 0;
    localparam int DROB_CTRL_MORE_BIT = 1;
    localparam int DROB_CTRL_CLR_BIT = 2;
    localparam logic [31:0] DROB_CTRL_RESET = 32'h0000_0000;

    // ========================================================
    // Record layout
    localparam int DROB_REC_BYTES = 16;
    localparam int DROB_BASE_BYTES = 4;
    localparam logic [6:0] DROB_TYPE_DIG_IN = 7'h70;
    localparam logic [6:0] DROB_TYPE_ANA_IN = 7'h71;
    localparam logic [6:0] DROB_TYPE_DIG_OUT = 7'h72;
    localparam logic [6:0] DROB_TYPE_ANA_OUT = 7'h73;
    localparam logic [6:0] DROB_TYPE_ANA_IO = 7'h74;
    localparam logic [7:0] DROB_DIAG_BITS = 8'h08;
    localparam logic [7:0] DROB_CHAN_COUNT = 8'h08;
    localparam int DROB_NUM_INPUTS = 16;
    localparam int DROB_NUM_GROUPS = 4;
    localparam int DROB_NUM_METERS = 3;

    // Interrupt status bits
    localparam int DROB_IRQ_LOST_BIT = 0;
    localparam int DROB_IRQ_ERR_BIT = 1;
    localparam logic [31:0] DROB_STAT_RESET = 32'h0000_0000;
    localparam logic [31:0] DROB_MASK_RESET = 32'h0000_0000;

    typedef enum logic {
        DROB_MODE_FREQ,
        DROB_MODE_PWM
    } drob_mode_t;

    // Event carrier from the I/O logic
    typedef struct packed {
        logic [DROB_NUM_INPUTS-1:0] in_lost;
        logic [DROB_NUM_METERS-1:0] meas_end;
        logic [DROB_NUM_METERS-1:0] meas_busy;
        logic [DROB_NUM_GROUPS-1:0] group_err;
        logic [DROB_NUM_METERS-1:0] meter_err;
    } drob_events_t;

endpackage

// File: drob_sticky.sv
/*
 * Bank of sticky flags: set by hardware pulses, cleared by a
 * clear vector. Set wins over a clear in the same cycle.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
module drob_sticky #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Flag control
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    // Flag state
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags;

    initial begin
        if (WIDTH < 1) begin
            $error("drob_sticky: WIDTH must be at least 1");
        end
    end

    always_comb begin
        next_flags = (flags & ~clr) | set;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule

// File: drob_sva.sv
/*
 * Checker for the diagnostic record builder, bound to drob_top.
 * Assumes an APB master that holds paddr and pwrite while pready is high.
 */
`timescale 1ns/100ps
module drob_sva
    import drob_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Record source
    input wire logic [31:0] base_record
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ========================================================
    // Read completion helper
    logic rd_done;
    assign rd_done = psel && penable && pready && !pwrite;

    // ========================================================
    // Assertions
    chk_wait_state: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing one cycle into the access phase");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_slverr_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_zero: assert property (
        pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    chk_base_copy: assert property (
        rd_done && paddr == DROB_OFF_REC0 |-> prdata == $past(base_record))
        else $error("record bytes 0 to 3 differ from base record");
    chk_type_code: assert property (
        rd_done && paddr == DROB_OFF_REC1 |-> prdata[6:0] == 7'h70)
        else $error("channel type code wrong");
    chk_count_bytes: assert property (
        rd_done && paddr == DROB_OFF_REC1 |-> prdata[23:8] == 16'h0808)
        else $error("bit or channel count byte wrong");
    chk_resv_bit: assert property (
        rd_done && paddr == DROB_OFF_REC1 |-> !prdata[31])
        else $error("byte 7 bit 7 not zero");
    chk_odd_bits: assert property (
        rd_done && paddr == DROB_OFF_REC2 |-> (prdata & 32'hAAAA_AAAA) == 0)
        else $error("odd lost-input bit set");
    chk_meter_zero: assert property (
        rd_done && paddr == DROB_OFF_REC3 |-> (prdata & 32'hFFFE_FEFE) == 0)
        else $error("fixed bits of bytes 12 to 15 set");
endmodule

bind drob_top drob_sva drob_sva_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .base_record(base_record)
);

// File: drob_top.sv
/*
 * Extended diagnostic record builder with APB register access.
 * Builds the 16-byte record for frequency-measurement or PWM mode
 * from the base record and live event inputs from the I/O logic.
 * Assumes APB signals synchronous to core_clk and event pulses
 * one cycle wide, also synchronous to core_clk.
 * A pulse held high for several cycles counts as several events.
 * Group and meter error inputs are levels; group errors, and meter errors in
 * frequency mode only, are shown live, not latched; software that needs history reads the status register.
 * Changing the mode bit drops every pending and lost meter flag.
 */
`timescale 1ns/100ps
module drob_top #(
    parameter int NUM_INPUTS = drob_pkg::DROB_NUM_INPUTS,
    parameter int NUM_METERS = drob_pkg::DROB_NUM_METERS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event inputs from the I/O logic
    input wire drob_pkg::drob_events_t events,
    // Base record bytes 0..3 from the basic diagnostic logic
    input wire logic [31:0] base_record,
    // Interrupt
    output logic irq
);
    import drob_pkg::*;

    initial begin
        if (NUM_INPUTS != DROB_NUM_INPUTS || NUM_METERS != DROB_NUM_METERS)
        begin
            $error("drob_top: record layout fixes 16 inputs, 3 meters");
        end
    end

    // ========================================================
    // Control and status registers
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] mask;
    logic [31:0] next_mask;
    logic [1:0] stat;
    logic [1:0] next_stat;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic [31:0] rec_word [4];

    drob_mode_t mode;
    logic access;
    logic wr_en;
    logic rd_en;
    logic soft_clr;

    // ========================================================
    // Address decode
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_known;

    always_comb begin
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        hit_known = 1'b1;
        case (paddr)
            DROB_OFF_CTRL: hit_ctrl = 1'b1;
            DROB_OFF_STAT: hit_stat = 1'b1;
            DROB_OFF_MASK: hit_mask = 1'b1;
            DROB_OFF_BASE, DROB_OFF_REC0, DROB_OFF_REC1: hit_known = 1'b1;
            DROB_OFF_REC2, DROB_OFF_REC3: hit_known = 1'b1;
            default: hit_known = 1'b0;
        endcase
    end

    assign mode = drob_mode_t'(ctrl[DROB_CTRL_MODE_BIT]);
    // One wait state: the access is taken in its first cycle and
    // answered in the next, so no access is ever taken twice
    assign access = psel & penable & ~pready;
    assign wr_en = access & pwrite & pstrb[0];
    assign rd_en = access & ~pwrite;
    assign soft_clr = wr_en && hit_ctrl && pwdata[DROB_CTRL_CLR_BIT];

    // ========================================================
    // Lost-interrupt flags
    // A process interrupt is lost when a new one arrives while its
    // flag from the previous event is still pending delivery.
    logic [NUM_METERS-1:0] meas_pend;
    logic [NUM_INPUTS-1:0] in_lost_set;
    logic [NUM_METERS-1:0] meas_lost_set;
    logic [NUM_INPUTS-1:0] in_lost;
    logic [NUM_METERS-1:0] meas_lost;
    logic [NUM_METERS-1:0] meas_evt;
    logic [NUM_INPUTS-1:0] in_clr;
    logic [NUM_METERS-1:0] meas_clr;

    // Integration expiry counts only while measurement is active
    assign meas_evt = events.meas_end & events.meas_busy;
    assign in_lost_set = events.in_lost;
    // A missed end-of-integration while one is still pending is lost
    assign meas_lost_set = (mode == DROB_MODE_FREQ) ?
                           (meas_evt & meas_pend) : '0;

    // ========================================================
    // Clear vectors for the two flag banks
    always_comb begin
        in_clr = {NUM_INPUTS{soft_clr}};
        meas_clr = {NUM_METERS{soft_clr}};
        // Leaving frequency mode drops the meter flags so PWM reads zero
        if (mode == DROB_MODE_PWM) begin
            meas_clr = '1;
        end
    end

    // ========================================================
    // Meter pending state
    // Limitation: one pending slot per meter, so a third end event
    // before software clears is counted the same as the second
    logic [NUM_METERS-1:0] next_meas_pend;

    always_comb begin
        next_meas_pend = meas_pend;
        if (mode == DROB_MODE_FREQ) begin
            next_meas_pend = meas_pend | meas_evt;
        end
        if (soft_clr || mode == DROB_MODE_PWM) begin
            next_meas_pend = meas_evt & {NUM_METERS{mode == DROB_MODE_FREQ}};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meas_pend <= '0;
        end else begin
            meas_pend <= next_meas_pend;
        end
    end

    // ========================================================
    // Sticky lost flags, one bank per source
    drob_sticky #(
        .WIDTH(NUM_INPUTS)
    ) u_in_lost (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set(in_lost_set),
        .clr(in_clr),
        .flags(in_lost)
    );

    drob_sticky #(
        .WIDTH(NUM_METERS)
    ) u_meas_lost (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set(meas_lost_set),
        .clr(meas_clr),
        .flags(meas_lost)
    );

    // ========================================================
    // Record assembly
    logic [7:0] rec_byte [DROB_REC_BYTES];

    always_comb begin
        // Zero first, so every reserved and fixed bit reads zero
        for (int b = 0; b < DROB_REC_BYTES; b++) begin
            rec_byte[b] = 8'h00;
        end
        for (int b = 0; b < DROB_BASE_BYTES; b++) begin
            rec_byte[b] = base_record[8*b +: 8];
        end
        rec_byte[4] = {ctrl[DROB_CTRL_MORE_BIT], DROB_TYPE_DIG_IN};
        rec_byte[5] = DROB_DIAG_BITS;
        rec_byte[6] = DROB_CHAN_COUNT;
        if (mode == DROB_MODE_FREQ) begin
            rec_byte[7] = {1'b0, events.meter_err, events.group_err};
        end else begin
            rec_byte[7] = {4'h0, events.group_err};
        end
        for (int i = 0; i < NUM_INPUTS; i++) begin
            rec_byte[8 + i/4][2*(i%4)] = in_lost[i];
        end
        if (mode == DROB_MODE_FREQ) begin
            for (int m = 0; m < NUM_METERS; m++) begin
                rec_byte[12 + m][0] = meas_lost[m];
            end
        end
    end

    always_comb begin
        for (int w = 0; w < 4; w++) begin
            rec_word[w] = {rec_byte[4*w+3], rec_byte[4*w+2],
                           rec_byte[4*w+1], rec_byte[4*w]};
        end
    end

    // ========================================================
    // Interrupt status: any new lost flag, group error or, in frequency mode, meter error
    logic [1:0] stat_set;
    logic [1:0] stat_clr;

    assign stat_set[DROB_IRQ_LOST_BIT] = |in_lost_set | |meas_lost_set;
    assign stat_set[DROB_IRQ_ERR_BIT] = |events.group_err |
        ((mode == DROB_MODE_FREQ) & |events.meter_err);
    assign stat_clr = (wr_en && hit_stat) ? pwdata[1:0] : 2'b00;

    always_comb begin
        // Set wins over a write-one-to-clear in the same cycle
        next_stat = (stat & ~stat_clr) | stat_set;
        next_irq = |(next_stat & mask[1:0]);
    end

    // Irq follows the status being stored, so it never lags a new
    // event; a mask write takes effect one cycle later
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat <= DROB_STAT_RESET[1:0];
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            irq <= next_irq;
        end
    end

    // ========================================================
    // Control and mask registers
    always_comb begin
        next_ctrl = ctrl;
        next_mask = mask;
        if (wr_en && hit_ctrl) begin
            // Clear is a self-clearing strobe, never stored
            next_ctrl = {30'h0, pwdata[1:0]};
        end
        if (wr_en && hit_mask) begin
            next_mask = {30'h0, pwdata[1:0]};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= DROB_CTRL_RESET;
            mask <= DROB_MASK_RESET;
        end else begin
            ctrl <= next_ctrl;
            mask <= next_mask;
        end
    end

    // ========================================================
    // APB answer
    // Writes return zero data; a refused access raises pslverr for
    // the one cycle that pready stands
    always_comb begin
        next_pready = access;
        next_pslverr = access & ~hit_known;
        next_prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                DROB_OFF_CTRL: next_prdata = ctrl;
                DROB_OFF_BASE: next_prdata = base_record;
                DROB_OFF_REC0: next_prdata = rec_word[0];
                DROB_OFF_REC1: next_prdata = rec_word[1];
                DROB_OFF_REC2: next_prdata = rec_word[2];
                DROB_OFF_REC3: next_prdata = rec_word[3];
                DROB_OFF_STAT: next_prdata = {30'h0, stat};
                DROB_OFF_MASK: next_prdata = mask;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for drob_top: APB read and write sequences.
 * Assumes the package constants and the hand-over latencies.
 */
`timescale 1ns/100ps
module tb_top;
    import drob_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    drob_events_t ev = '0;
    logic [31:0] base_record = 32'h1234_5678;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    drob_top drob_top_i (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .events(ev),
        .base_record(base_record),
        .irq(irq)
    );

    // ========================================================
    // Tasks
    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    // Request held until pready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(string name, logic [11:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask

    // ========================================================
    // Timeout
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    // ========================================================
    // Sequence
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        rchk("ctrl", DROB_OFF_CTRL, DROB_CTRL_RESET);
        rchk("mask", DROB_OFF_MASK, DROB_MASK_RESET);
        rchk("rec0", DROB_OFF_REC0, 32'h1234_5678);
        ev.group_err <= 4'h5;
        ev.meter_err <= 3'h5;
        ev.meas_busy <= 3'h7;
        rchk("rec1", DROB_OFF_REC1, 32'h5508_0870);
        apb(1'b1, DROB_OFF_CTRL, 32'h0000_0002);
        rchk("rec1 more", DROB_OFF_REC1, 32'h5508_08F0);
        // Lost inputs 0, 5, 10 and 15 in one pulse
        @(posedge core_clk);
        ev.in_lost <= 16'h8421;
        @(posedge core_clk);
        ev.in_lost <= 16'h0000;
        rchk("rec2", DROB_OFF_REC2, 32'h4010_0401);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, DROB_OFF_MASK, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        chk("irq set", {31'h0, irq}, 32'h1);
        apb(1'b1, DROB_OFF_STAT, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        chk("irq clr", {31'h0, irq}, 32'h0);
        // Meter 1 ends twice, meter 0 once: only meter 1 is lost
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            ev.meas_end <= (k == 0) ? 3'h3 : 3'h2;
            @(posedge core_clk);
            ev.meas_end <= 3'h0;
        end
        rchk("rec3", DROB_OFF_REC3, 32'h0000_0100);
        apb(1'b1, DROB_OFF_CTRL, 32'h0000_0006);
        rchk("rec2 clr", DROB_OFF_REC2, 32'h0);
        rchk("rec3 clr", DROB_OFF_REC3, 32'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            ev.meas_end <= 3'h4;
            @(posedge core_clk);
            ev.meas_end <= 3'h0;
        end
        rchk("rec3 m2", DROB_OFF_REC3, 32'h0001_0000);
        // Pulse width mode hides meter errors and bytes 12 to 15
        apb(1'b1, DROB_OFF_CTRL, 32'h0000_0003);
        rchk("rec1 pwm", DROB_OFF_REC1, 32'h0508_08F0);
        rchk("rec3 pwm", DROB_OFF_REC3, 32'h0);
        apb(1'b1, DROB_OFF_REC0, 32'hFFFF_FFFF);
        rchk("rec0 ro", DROB_OFF_REC0, 32'h1234_5678);
        rchk("unmapped", 12'h0FC, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        rchk("base", DROB_OFF_BASE, 32'h1234_5678);
        rchk("mask wr", DROB_OFF_MASK, 32'h0000_0001);
        rchk("stat", DROB_OFF_STAT, 32'h0000_0003);
        stop_test();
    end
endmodule
